// [common/ccache_pkg.sv]
// Shared constants and carrier types for the configurable instruction, data or split cache.
// Assumes a 32-bit core local bus and a 32-bit external bus on core_clk.
package ccache_pkg;

	localparam int ADDR_W     = 32;
	localparam int DATA_W     = 32;
	localparam int BE_W       = 4;
	localparam int NUM_LINES  = 512;
	localparam int NUM_WORDS  = 2048;
	localparam int LINE_BYTES = 16;
	localparam int LINE_WORDS = 4;
	localparam int LINE_W     = 9;
	localparam int WORD_IDX_W = 11;
	localparam int WSEL_W     = 2;
	localparam int TAG_LSB    = 12;
	localparam int TAG_W      = 20;
	localparam int OFFS_LSB   = 4;
	localparam int WSEL_LSB   = 2;

	// Organization codes held in the configuration register.
	localparam logic [1:0] ORG_ICACHE = 2'h0;
	localparam logic [1:0] ORG_DCACHE = 2'h1;
	localparam logic [1:0] ORG_SPLIT  = 2'h2;

	// Split organization: instruction half is line 0..255, data half 256..511.
	localparam logic HALF_INSN = 1'h0;
	localparam logic HALF_DATA = 1'h1;

	typedef struct packed {
		logic       enable;
		logic       invalidate;
		logic [1:0] org;
	} ccache_cfg_t;

	localparam ccache_cfg_t CFG_RESET = '{enable: 1'h0, invalidate: 1'h0, org: ORG_ICACHE};

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              write;
		logic              ifetch;
		logic [BE_W-1:0]   be;
		logic [DATA_W-1:0] wdata;
	} ccache_req_t;

	typedef struct packed {
		logic              valid;
		logic              hit;
		logic              miss;
		logic [DATA_W-1:0] rdata;
	} ccache_rsp_t;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic              burst;
		logic [ADDR_W-1:0] addr;
		logic [BE_W-1:0]   be;
		logic [DATA_W-1:0] wdata;
	} ccache_ext_req_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FILL,
		ST_EXT
	} ccache_state_t;

endpackage

// [dv/ccache_ext_mem.sv]
// Behavioural external memory answering the cache's external bus.
// Assumes ext_req holds until the edge after its last ack.
`timescale 1ns/10ps
module ccache_ext_mem (
	// Clock and reset.
	input wire logic                        core_clk,
	input wire logic                        rst,
	// Bus from the cache.
	input wire ccache_pkg::ccache_ext_req_t ext_req,
	input wire logic [3:0]                  lat,
	output logic                            ext_ack,
	output logic [31:0]                     ext_rdata,
	// Record of writes.
	output logic [31:0]                     wr_addr,
	output logic [3:0]                      wr_be,
	output logic [31:0]                     wr_data,
	output logic [7:0]                      wr_cnt
);
	import ccache_pkg::*;
	logic [3:0] wait_reg;
	logic [1:0] beat_reg;
	logic [31:0] ba;
	assign ba = ext_req.addr + {28'h0, beat_reg, 2'h0};
	// Data is inverted each idle cycle so stale values never look valid.
	always_ff @(posedge core_clk) begin
		ext_rdata <= ~ext_rdata;
		ext_ack <= 1'b0;
		if (rst) begin
			ext_rdata <= 32'h0;
			wait_reg <= 4'h0;
			beat_reg <= 2'h0;
			wr_cnt <= 8'h0;
		end else if (!ext_req.valid) begin
			wait_reg <= 4'h0;
			beat_reg <= 2'h0;
		end else if (ext_ack) begin
			wait_reg <= 4'h0;
			beat_reg <= beat_reg + 2'h1;
		end else if (wait_reg < lat) begin
			wait_reg <= wait_reg + 4'h1;
		end else begin
			ext_ack <= 1'b1;
			ext_rdata <= {ba[15:0] ^ 16'hC3A5, ba[15:2], 2'h0};
			if (ext_req.write) begin
				wr_addr <= ext_req.addr;
				wr_be <= ext_req.be;
				wr_data <= ext_req.wdata;
				wr_cnt <= wr_cnt + 8'h1;
			end
		end
	end
endmodule

// [dv/ccache_props.sv]
// Checker for the cache's config port, core bus and external bus.
// Assumes it is bound to ccache_top and sees only its ports.
`timescale 1ns/10ps
module ccache_props (
	// Clock and reset.
	input wire logic                        core_clk,
	input wire logic                        rst,
	// Config port.
	input wire logic                        cfg_wr,
	input wire logic                        cfg_supervisor,
	input wire ccache_pkg::ccache_cfg_t     cfg_wdata,
	input wire ccache_pkg::ccache_cfg_t     cfg_rdata,
	input wire logic                        cfg_denied,
	// Core bus and external bus.
	input wire logic                        core_req_valid,
	input wire ccache_pkg::ccache_req_t     core_req,
	input wire logic                        core_ready,
	input wire ccache_pkg::ccache_rsp_t     core_rsp,
	input wire ccache_pkg::ccache_ext_req_t ext_req,
	input wire logic                        ext_ack
);
	import ccache_pkg::*;
	logic [2:0] beats_reg;
	wire take = core_req_valid && core_ready;
	wire cached = cfg_rdata.enable && (cfg_rdata.org == ORG_SPLIT
		|| (cfg_rdata.org == ORG_ICACHE && core_req.ifetch)
		|| (cfg_rdata.org == ORG_DCACHE && !core_req.ifetch));
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Counts the acks of the current external request.
	always_ff @(posedge core_clk) begin
		if (rst || !ext_req.valid) beats_reg <= 3'h0;
		else if (ext_ack) beats_reg <= beats_reg + 3'h1;
	end
	sequence last_beat_s;
		ext_req.valid && ext_req.burst && ext_ack && beats_reg == 3'h3;
	endsequence
	sequence done_s;
		!ext_req.valid && core_rsp.valid && core_ready;
	endsequence
	take_ans_a: assert property (take |=> core_rsp.valid || core_rsp.miss || ext_req.valid)
		else $error("access taken without an answer");
	hit_once_a: assert property (core_rsp.hit |-> core_rsp.valid && core_ready
		&& !ext_req.valid && $past(take)) else $error("hit answer out of place");
	miss_fetch_a: assert property (core_rsp.miss |-> !core_ready && ext_req.valid
		&& ext_req.burst && !ext_req.write && ext_req.addr[3:0] == 4'h0)
		else $error("miss without aligned line fetch");
	beat_hold_a: assert property (ext_req.valid && ext_req.burst && ext_ack
		&& beats_reg < 3'h3 |=> ext_req.valid) else $error("line fetch ended early");
	fill_done_a: assert property (last_beat_s |=> done_s)
		else $error("line fill did not finish");
	write_thru_a: assert property (take && core_req.write |=> ext_req.valid
		&& ext_req.write && !ext_req.burst && ext_req.addr == $past(core_req.addr)
		&& ext_req.be == $past(core_req.be)) else $error("write not sent out");
	single_end_a: assert property (ext_req.valid && !ext_req.burst && ext_ack |=> done_s)
		else $error("single access did not finish");
	bypass_a: assert property (take && !core_req.write && !cached |=> ext_req.valid
		&& !ext_req.burst && !core_rsp.miss && ext_req.addr == $past(core_req.addr))
		else $error("uncached read not bypassed");
	cfg_deny_a: assert property (cfg_wr && !cfg_supervisor |=> cfg_denied
		&& $stable(cfg_rdata)) else $error("user config write not refused");
	cfg_take_a: assert property (cfg_wr && cfg_supervisor |=> !cfg_denied
		&& cfg_rdata.org == $past(cfg_wdata.org) && cfg_rdata.enable == $past(cfg_wdata.enable))
		else $error("config write not taken");
endmodule
bind ccache_top ccache_props u_props (.core_clk, .rst, .cfg_wr, .cfg_supervisor, .cfg_wdata,
	.cfg_rdata, .cfg_denied, .core_req_valid, .core_req, .core_ready, .core_rsp, .ext_req,
	.ext_ack);

// [dv/tb.sv]
// Self-checking bench for the configurable cache.
// Assumes the external memory model answers the external bus.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
	import ccache_pkg::*;
	logic core_clk, rst, cfg_wr, cfg_supervisor, cfg_denied, core_req_valid, core_ready, ext_ack;
	ccache_cfg_t cfg_wdata, cfg_rdata;
	ccache_req_t core_req;
	ccache_rsp_t core_rsp;
	ccache_ext_req_t ext_req;
	logic [31:0] ext_rdata, wr_addr, wr_data;
	logic [3:0] lat, wr_be;
	logic [7:0] wr_cnt;
	int err_total, comparisons, cyc;
	ccache_top dut (.core_clk, .rst, .cfg_wr, .cfg_supervisor, .cfg_wdata, .cfg_rdata,
		.cfg_denied, .core_req_valid, .core_req, .core_ready, .core_rsp, .ext_req,
		.ext_ack, .ext_rdata);
	ccache_ext_mem u_mem (.core_clk, .rst, .ext_req, .lat, .ext_ack, .ext_rdata,
		.wr_addr, .wr_be, .wr_data, .wr_cnt);
	function automatic logic [31:0] ew(input logic [31:0] a);
		return {a[15:0] ^ 16'hC3A5, a[15:2], 2'h0};
	endfunction
	task automatic end_sim();
		$display("Comparisons %0d, errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic cfgw(input logic s, input ccache_cfg_t c);
		ccache_cfg_t e;
		e = cfg_rdata;
		if (s) e = {c.enable, 1'b0, c.org};
		@(negedge core_clk);
		cfg_wr = 1'b1;
		cfg_supervisor = s;
		cfg_wdata = c;
		@(negedge core_clk);
		cfg_wr = 1'b0;
		`CHK(cfg_denied, !s)
		`CHK(cfg_rdata, e)
	endtask
	task automatic acc(input logic [31:0] a, input logic w, i, input logic [3:0] be,
		input logic [31:0] d, output logic [31:0] rd, output logic h, m);
		@(negedge core_clk);
		core_req_valid = 1'b1;
		core_req = '{a, w, i, be, d};
		@(negedge core_clk);
		core_req_valid = 1'b0;
		m = 1'b0;
		for (int n = 0; n < 200 && core_rsp.valid !== 1'b1; n++) begin
			if (core_rsp.miss === 1'b1) m = 1'b1;
			@(negedge core_clk);
		end
		rd = core_rsp.rdata;
		h = core_rsp.hit;
	endtask
	task automatic rdchk(input logic [31:0] a, input logic i, eh, em);
		logic [31:0] rd;
		logic h, m;
		acc(a, 1'b0, i, 4'hF, 32'h0, rd, h, m);
		`CHK({h, m, rd}, {eh, em, ew(a)})
	endtask
	task automatic t_reset();
		`CHK(cfg_rdata, CFG_RESET)
		rdchk(32'h0000_0100, 1'b1, 1'b0, 1'b0);
		cfgw(1'b0, '{1'b1, 1'b0, ORG_SPLIT});
	endtask
	task automatic t_orgs();
		logic ci, cd;
		for (int o = 0; o < 4; o++) begin
			ci = (o == 0 || o == 2);
			cd = (o == 1 || o == 2);
			cfgw(1'b1, '{1'b1, 1'b1, o[1:0]});
			rdchk(32'h0000_4A10, 1'b1, 1'b0, ci);
			rdchk(32'h0000_4A10, 1'b1, ci, 1'b0);
			rdchk(32'h0000_6B28, 1'b0, 1'b0, cd);
			rdchk(32'h0000_6B28, 1'b0, cd, 1'b0);
		end
	endtask
	task automatic t_cap();
		lat = 4'h1;
		cfgw(1'b1, '{1'b1, 1'b1, ORG_ICACHE});
		rdchk(32'h0000_0040, 1'b1, 1'b0, 1'b1);
		rdchk(32'h0000_004C, 1'b1, 1'b1, 1'b0);
		rdchk(32'h0000_1040, 1'b1, 1'b0, 1'b1);
		rdchk(32'h0000_0040, 1'b1, 1'b1, 1'b0);
		rdchk(32'h0000_2040, 1'b1, 1'b0, 1'b1);
		rdchk(32'h0000_0040, 1'b1, 1'b0, 1'b1);
		cfgw(1'b1, '{1'b1, 1'b1, ORG_SPLIT});
		rdchk(32'h0000_0040, 1'b1, 1'b0, 1'b1);
		rdchk(32'h0000_1040, 1'b1, 1'b0, 1'b1);
		rdchk(32'h0000_0040, 1'b1, 1'b0, 1'b1);
	endtask
	task automatic t_write();
		logic [31:0] rd;
		logic h, m;
		logic [7:0] n;
		lat = 4'h3;
		cfgw(1'b1, '{1'b1, 1'b1, ORG_DCACHE});
		rdchk(32'h0000_0080, 1'b0, 1'b0, 1'b1);
		n = wr_cnt;
		acc(32'h0000_0080, 1'b1, 1'b0, 4'h3, 32'h1234_ABCD, rd, h, m);
		`CHK({wr_cnt, wr_addr, wr_be, wr_data[15:0]}, {n + 8'h1, 32'h0000_0080, 4'h3, 16'hABCD})
		acc(32'h0000_0080, 1'b0, 1'b0, 4'hF, 32'h0, rd, h, m);
		`CHK({h, rd}, {1'b1, ew(32'h0000_0080) & 32'hFFFF_0000 | 32'h0000_ABCD})
		acc(32'h0000_3080, 1'b1, 1'b0, 4'hF, 32'h5555_AAAA, rd, h, m);
		`CHK({wr_cnt, wr_addr, wr_data}, {n + 8'h2, 32'h0000_3080, 32'h5555_AAAA})
		rdchk(32'h0000_3080, 1'b0, 1'b0, 1'b1);
		cfgw(1'b1, '{1'b1, 1'b0, ORG_DCACHE});
		rdchk(32'h0000_3080, 1'b0, 1'b1, 1'b0);
		cfgw(1'b1, '{1'b1, 1'b0, ORG_SPLIT});
		cfgw(1'b1, '{1'b1, 1'b0, ORG_DCACHE});
		rdchk(32'h0000_3080, 1'b0, 1'b0, 1'b1);
		cfgw(1'b1, '{1'b0, 1'b0, ORG_DCACHE});
		rdchk(32'h0000_3080, 1'b0, 1'b0, 1'b0);
		lat = 4'h0;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end
	initial begin
		rst = 1'b1;
		cfg_wr = 1'b0;
		cfg_supervisor = 1'b0;
		cfg_wdata = '0;
		core_req_valid = 1'b0;
		core_req = '0;
		lat = 4'h0;
		repeat (10) @(negedge core_clk);
		rst = 1'b0;
		t_reset();
		t_orgs();
		t_cap();
		t_write();
		end_sim();
	end
endmodule

// [hw/ccache_store.sv]
// Tag array, valid bits and data array of the cache.
// Assumes the controller drives all write ports on core_clk; reads are combinational.
`timescale 1ns/10ps
module ccache_store (
	// Clock and reset.
	input  wire logic                              core_clk,
	input  wire logic                              rst,
	// Lookup.
	input  wire logic [ccache_pkg::LINE_W-1:0]     rd_line,
	input  wire logic [ccache_pkg::WORD_IDX_W-1:0] rd_word,
	output logic                                   rd_valid,
	output logic [ccache_pkg::TAG_W-1:0]           rd_tag,
	output logic [ccache_pkg::DATA_W-1:0]          rd_data,
	// Single word update on a write hit.
	input  wire logic                              word_we,
	input  wire logic [ccache_pkg::WORD_IDX_W-1:0] word_idx,
	input  wire logic [ccache_pkg::BE_W-1:0]       word_be,
	input  wire logic [ccache_pkg::DATA_W-1:0]     word_data,
	// Whole line update at the end of a fill.
	input  wire logic                              line_we,
	input  wire logic [ccache_pkg::LINE_W-1:0]     line_idx,
	input  wire logic [ccache_pkg::TAG_W-1:0]      line_tag,
	input  wire logic [ccache_pkg::LINE_WORDS*ccache_pkg::DATA_W-1:0] line_data,
	// Clears every valid bit.
	input  wire logic                              inval_all
);
	import ccache_pkg::*;

	logic [TAG_W-1:0]     tag_mem [NUM_LINES];
	logic [DATA_W-1:0]    data_mem [NUM_WORDS];
	logic [NUM_LINES-1:0] valid_reg;
	logic [NUM_LINES-1:0] valid_next;

	assign rd_valid = valid_reg[rd_line];
	assign rd_tag   = tag_mem[rd_line];
	assign rd_data  = data_mem[rd_word];

	always_comb begin
		valid_next = valid_reg;
		if (line_we) begin
			valid_next[line_idx] = 1'b1;
		end
		if (inval_all) begin
			valid_next = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			valid_reg <= '0;
		end else begin
			valid_reg <= valid_next;
		end
	end

	// A 512-entry tag array and a 2048 x 32 data array.
	always_ff @(posedge core_clk) begin
		if (line_we) begin
			tag_mem[line_idx] <= line_tag;
			for (int w = 0; w < LINE_WORDS; w++) begin
				data_mem[{line_idx, WSEL_W'(w)}] <= line_data[w*DATA_W +: DATA_W];
			end
		end else if (word_we) begin
			for (int b = 0; b < BE_W; b++) begin
				if (word_be[b]) begin
					data_mem[word_idx][b*8 +: 8] <= word_data[b*8 +: 8];
				end
			end
		end
	end

endmodule

// [hw/ccache_top.sv]
// Configurable 8-Kbyte direct-mapped cache on the core local bus.
// Assumes core and external bus logic on core_clk; no input needs synchronising.
`timescale 1ns/10ps
module ccache_top (
	// Clock and reset.
	input  wire logic                         core_clk,
	input  wire logic                         rst,
	// Privileged configuration port.
	input  wire logic                         cfg_wr,
	input  wire logic                         cfg_supervisor,
	input  wire ccache_pkg::ccache_cfg_t      cfg_wdata,
	output ccache_pkg::ccache_cfg_t           cfg_rdata,
	output logic                              cfg_denied,
	// Core local bus.
	input  wire logic                         core_req_valid,
	input  wire ccache_pkg::ccache_req_t      core_req,
	output logic                              core_ready,
	output ccache_pkg::ccache_rsp_t           core_rsp,
	// External bus.
	output ccache_pkg::ccache_ext_req_t       ext_req,
	input  wire logic                         ext_ack,
	input  wire logic [ccache_pkg::DATA_W-1:0] ext_rdata
);
	import ccache_pkg::*;

	ccache_cfg_t                       cache_config_reg, cache_config_next;
	logic                              cfg_denied_reg, cfg_denied_next;
	ccache_state_t                     state_reg, state_next;
	logic                              ready_reg, ready_next;
	ccache_rsp_t                       rsp_reg, rsp_next;
	ccache_ext_req_t                   ext_reg, ext_next;
	ccache_req_t                       req_reg, req_next;
	logic [LINE_W-1:0]                 fill_line_reg, fill_line_next;
	logic [WSEL_W-1:0]                 beat_reg, beat_next;
	logic                              stale_reg, stale_next;
	logic [DATA_W-1:0]                 fill_buf_reg [LINE_WORDS];
	logic [DATA_W-1:0]                 fill_buf_next [LINE_WORDS];

	logic                              accept;
	logic                              cacheable;
	logic                              hit;
	logic                              cfg_take;
	logic [LINE_W-1:0]                 lk_line;
	logic                              st_valid;
	logic [TAG_W-1:0]                  st_tag;
	logic [DATA_W-1:0]                 st_data;
	logic                              word_we;
	logic                              line_we;
	logic                              inval_all;
	logic [LINE_WORDS*DATA_W-1:0]      line_data;

	// Maps an access onto its line; split mode selects a half by access type.
	function automatic logic [LINE_W-1:0] line_index(input logic [ADDR_W-1:0] addr,
			input logic [1:0] org, input logic ifetch);
		if (org == ORG_SPLIT) begin
			line_index = {(ifetch ? HALF_INSN : HALF_DATA), addr[TAG_LSB-1:OFFS_LSB]};
		end else begin
			line_index = addr[TAG_LSB:OFFS_LSB];
		end
	endfunction

	// Tells whether the current organization caches this access type.
	function automatic logic is_cacheable(input ccache_cfg_t cfg, input logic ifetch);
		unique case (cfg.org)
			ORG_ICACHE: is_cacheable = cfg.enable & ifetch;
			ORG_DCACHE: is_cacheable = cfg.enable & ~ifetch;
			ORG_SPLIT:  is_cacheable = cfg.enable;
			default:    is_cacheable = 1'b0;
		endcase
	endfunction

	assign accept    = core_req_valid & ready_reg;
	assign lk_line   = line_index(core_req.addr, cache_config_reg.org, core_req.ifetch);
	assign cacheable = is_cacheable(cache_config_reg, core_req.ifetch);
	assign hit       = cacheable & st_valid & (st_tag == core_req.addr[ADDR_W-1:TAG_LSB]);
	assign cfg_take  = cfg_wr & cfg_supervisor;

	always_comb begin
		for (int w = 0; w < LINE_WORDS; w++) begin
			line_data[w*DATA_W +: DATA_W] = fill_buf_next[w];
		end
	end

	ccache_store u_store (
		.core_clk  (core_clk),
		.rst       (rst),
		.rd_line   (lk_line),
		.rd_word   ({lk_line, core_req.addr[OFFS_LSB-1:WSEL_LSB]}),
		.rd_valid  (st_valid),
		.rd_tag    (st_tag),
		.rd_data   (st_data),
		.word_we   (word_we),
		.word_idx  ({lk_line, core_req.addr[OFFS_LSB-1:WSEL_LSB]}),
		.word_be   (core_req.be),
		.word_data (core_req.wdata),
		.line_we   (line_we),
		.line_idx  (fill_line_reg),
		.line_tag  (req_reg.addr[ADDR_W-1:TAG_LSB]),
		.line_data (line_data),
		.inval_all (inval_all)
	);

	// Configuration: only supervisor writes land; a change of layout flushes the cache.
	always_comb begin
		cache_config_next = cache_config_reg;
		cfg_denied_next   = cfg_wr & ~cfg_supervisor;
		inval_all         = 1'b0;
		if (cfg_take) begin
			cache_config_next            = cfg_wdata;
			cache_config_next.invalidate = 1'b0;
			inval_all = cfg_wdata.invalidate | (cfg_wdata.org != cache_config_reg.org);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cache_config_reg <= CFG_RESET;
			cfg_denied_reg   <= 1'b0;
		end else begin
			cache_config_reg <= cache_config_next;
			cfg_denied_reg   <= cfg_denied_next;
		end
	end

	// Access sequencing: lookup, line fill and external single cycles.
	always_comb begin
		state_next     = state_reg;
		ready_next     = ready_reg;
		rsp_next       = '0;
		ext_next       = ext_reg;
		req_next       = req_reg;
		fill_line_next = fill_line_reg;
		beat_next      = beat_reg;
		stale_next     = stale_reg | inval_all;
		fill_buf_next  = fill_buf_reg;
		word_we        = 1'b0;
		line_we        = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (accept) begin
					req_next       = core_req;
					fill_line_next = lk_line;
					ready_next     = 1'b0;
					stale_next     = inval_all;
					if (core_req.write) begin
						word_we    = hit;
						ext_next   = '{valid: 1'b1, write: 1'b1, burst: 1'b0,
							addr: core_req.addr, be: core_req.be,
							wdata: core_req.wdata};
						state_next = ST_EXT;
					end else if (hit) begin
						rsp_next   = '{valid: 1'b1, hit: 1'b1, miss: 1'b0,
							rdata: st_data};
						ready_next = 1'b1;
					end else if (cacheable) begin
						rsp_next.miss = 1'b1;
						ext_next   = '{valid: 1'b1, write: 1'b0, burst: 1'b1,
							addr: {core_req.addr[ADDR_W-1:OFFS_LSB], OFFS_LSB'(0)},
							be: '1, wdata: '0};
						beat_next  = '0;
						state_next = ST_FILL;
					end else begin
						ext_next   = '{valid: 1'b1, write: 1'b0, burst: 1'b0,
							addr: core_req.addr, be: core_req.be, wdata: '0};
						state_next = ST_EXT;
					end
				end
			end
			ST_FILL: begin
				if (ext_ack) begin
					fill_buf_next[beat_reg] = ext_rdata;
					beat_next = beat_reg + WSEL_W'(1);
					if (beat_reg == WSEL_W'(LINE_WORDS - 1)) begin
						ext_next.valid = 1'b0;
						line_we    = ~stale_next;
						rsp_next   = '{valid: 1'b1, hit: 1'b0, miss: 1'b0,
							rdata: fill_buf_next[req_reg.addr[OFFS_LSB-1:WSEL_LSB]]};
						ready_next = 1'b1;
						state_next = ST_IDLE;
					end
				end
			end
			ST_EXT: begin
				if (ext_ack) begin
					ext_next.valid = 1'b0;
					rsp_next   = '{valid: 1'b1, hit: 1'b0, miss: 1'b0,
						rdata: (req_reg.write ? '0 : ext_rdata)};
					ready_next = 1'b1;
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
				ready_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg     <= ST_IDLE;
			ready_reg     <= 1'b1;
			rsp_reg       <= '0;
			ext_reg       <= '0;
			req_reg       <= '0;
			fill_line_reg <= '0;
			beat_reg      <= '0;
			stale_reg     <= 1'b0;
			for (int w = 0; w < LINE_WORDS; w++) begin
				fill_buf_reg[w] <= '0;
			end
		end else begin
			state_reg     <= state_next;
			ready_reg     <= ready_next;
			rsp_reg       <= rsp_next;
			ext_reg       <= ext_next;
			req_reg       <= req_next;
			fill_line_reg <= fill_line_next;
			beat_reg      <= beat_next;
			stale_reg     <= stale_next;
			fill_buf_reg  <= fill_buf_next;
		end
	end

	assign cfg_rdata  = cache_config_reg;
	assign cfg_denied = cfg_denied_reg;
	assign core_ready = ready_reg;
	assign core_rsp   = rsp_reg;
	assign ext_req    = ext_reg;

endmodule
